/* rtl/ctu_control.sv */
// Control register and edge handling of the charge time unit.
`timescale 1ns/1ps
module ctu_control
  import ctu_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [15:0] reg_rdata_o,
  // System state
  input  wire logic        idle_mode_i,
  // Edge sources from pins
  input  wire logic        edge1_i,
  input  wire logic        edge2_i,
  // Measurement side
  output logic             unit_run_o,
  output logic             delay_gen_o,
  output logic             edge1_event_o,
  output logic             edge2_event_o,
  output logic             discharge_o,
  output logic             trigger_o
);

  ctu_control_type control_q;
  ctu_edge_type    edge_q;
  logic [1:0]      e1_sync_q;
  logic [1:0]      e2_sync_q;
  logic            e1_prev_q;
  logic            e2_prev_q;
  logic            run_d;
  logic            e1_rise;
  logic            e2_rise;
  logic            e1_pass;
  logic            e2_pass;

  //----------------------------------------------------------------------------
  // Helper functions
  //----------------------------------------------------------------------------
  // True when the register index selects the control register.
  function automatic logic is_control_addr(input logic [3:0] addr);
    return addr == CTU_ADDR_CONTROL_ONE;
  endfunction

  // Keeps only the implemented control bits of a bus word.
  function automatic logic [15:0] implemented_bits(input logic [15:0] word);
    return word & CTU_CONTROL_MASK;
  endfunction

  // Rising edge of a synchronised pin against its value one cycle earlier.
  function automatic logic rising(input logic now_val,
                                  input logic before_val);
    return now_val && !before_val;
  endfunction

  // In ordered mode a second edge waits for a first edge already seen.
  function automatic logic second_allowed(input logic ordered,
                                          input logic first_seen);
    return !ordered || first_seen;
  endfunction

  // Read data for a register index; unmapped indices read as zero.
  function automatic logic [15:0] read_word(input logic [3:0]      addr,
                                            input ctu_control_type ctl,
                                            input ctu_edge_type    edges);
    logic [15:0] word;
    word = 16'h0000;
    case (addr)
      CTU_ADDR_CONTROL_ONE: word = implemented_bits(ctl);
      CTU_ADDR_STATUS:      word = {14'h0, edges};
      default:              word = 16'h0000;
    endcase
    return word;
  endfunction

  //----------------------------------------------------------------------------
  // Control register
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_q <= CTU_CONTROL_RESET;
    end else if (reg_write_i && is_control_addr(reg_addr_i)) begin
      control_q <= implemented_bits(reg_wdata_i);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      // Read data stand in each cycle after a read request and are zero otherwise.
      reg_rdata_o <= read_word(reg_addr_i, control_q, edge_q);
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  //----------------------------------------------------------------------------
  // Run state
  //----------------------------------------------------------------------------
  // The unit runs when enabled, unless idle-stop is chosen and the core is idle.
  assign run_d = control_q.measure_unit_enable
               && !(control_q.idle_stop_select && idle_mode_i);

  //----------------------------------------------------------------------------
  // Edge input synchronisers
  //----------------------------------------------------------------------------
  // The pins are asynchronous; only the second stage feeds the edge detect.
  // The detect stage resets low to match the idle level of the pins, so no
  // false edge follows reset.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      e1_sync_q <= 2'h0;
      e1_prev_q <= 1'b0;
    end else begin
      e1_sync_q <= {e1_sync_q[0], edge1_i};
      e1_prev_q <= e1_sync_q[1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      e2_sync_q <= 2'h0;
      e2_prev_q <= 1'b0;
    end else begin
      e2_sync_q <= {e2_sync_q[0], edge2_i};
      e2_prev_q <= e2_sync_q[1];
    end
  end

  assign e1_rise = rising(e1_sync_q[1], e1_prev_q);
  assign e2_rise = rising(e2_sync_q[1], e2_prev_q);
  assign e1_pass = run_d && control_q.edge_gate_enable && e1_rise;
  // A second edge in ordered mode needs a first edge already seen.
  assign e2_pass = run_d && control_q.edge_gate_enable && e2_rise
                && second_allowed(control_q.edge_order_enable, edge_q.edge1_seen);

  //----------------------------------------------------------------------------
  // Edge tracking and outputs
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge_q <= '0;
    end else if (!run_d || !control_q.edge_gate_enable) begin
      edge_q <= '0;
    end else begin
      if (e1_pass) begin
        edge_q.edge1_seen <= 1'b1;
      end
      if (e2_pass) begin
        edge_q.edge2_seen <= 1'b1;
      end
    end
  end

  // Run and delay generation follow the register one cycle after a write.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unit_run_o  <= 1'b0;
      delay_gen_o <= 1'b0;
    end else begin
      unit_run_o  <= run_d;
      delay_gen_o <= run_d && control_q.delay_gen_enable;
    end
  end

  // Accepted edges leave as single-cycle pulses.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      edge1_event_o <= 1'b0;
      edge2_event_o <= 1'b0;
    end else begin
      edge1_event_o <= e1_pass;
      edge2_event_o <= e2_pass;
    end
  end

  // Discharge acts even while the unit is disabled, so a sensor can be
  // drained before a measurement is started.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      discharge_o <= 1'b0;
    end else begin
      discharge_o <= control_q.current_source_discharge;
    end
  end

  // The trigger fires once both edges of a measurement have been seen.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trigger_o <= 1'b0;
    end else begin
      trigger_o <= run_d && control_q.trigger_out_enable
                && edge_q.edge1_seen && edge_q.edge2_seen;
    end
  end

endmodule

/* rtl/ctu_pkg.sv */
// Constants and types of the charge time unit control register.
//------------------------------------------------------------------------------
// Summary of operation
// - The unit runs only while the enable bit 15 is set and is held off while it is clear.
// - With the idle-stop bit 13 set the unit halts in idle mode, otherwise it keeps running in idle.
// - Edge delay generation happens only while bit 12 is set.
// - Incoming edge events are blocked while bit 11 is clear and passed on while it is set.
// - With bit 10 set a second-edge event is accepted only after a first-edge event.
// - With bit 9 set the current source output is grounded, otherwise it is released.
// - The trigger output is active only while bit 8 is set.
// - Bit 14 and bits 7 to 0 read as zero and ignore writes.
// - Reset clears every writable control bit to zero.
//------------------------------------------------------------------------------
package ctu_pkg;

  localparam logic [3:0]  CTU_ADDR_CONTROL_ONE = 4'h0;
  localparam logic [15:0] CTU_CONTROL_RESET    = 16'h0000;
  localparam logic [15:0] CTU_CONTROL_MASK     = 16'hbf00;
  localparam logic [3:0]  CTU_ADDR_STATUS      = 4'h1;

  localparam int CTU_BIT_ENABLE    = 15;
  localparam int CTU_BIT_IDLE_STOP = 13;
  localparam int CTU_BIT_DELAY_GEN = 12;
  localparam int CTU_BIT_EDGE_GATE = 11;
  localparam int CTU_BIT_EDGE_ORD  = 10;
  localparam int CTU_BIT_DISCHARGE = 9;
  localparam int CTU_BIT_TRIG_EN   = 8;

  typedef struct packed {
    logic measure_unit_enable;
    logic reserved_14;
    logic idle_stop_select;
    logic delay_gen_enable;
    logic edge_gate_enable;
    logic edge_order_enable;
    logic current_source_discharge;
    logic trigger_out_enable;
    logic [7:0] reserved_low;
  } ctu_control_type;

  typedef struct packed {
    logic edge1_seen;
    logic edge2_seen;
  } ctu_edge_type;

endpackage

/* sim/ctu_checker.sv */
// Port assertions of the charge time unit control block.
`timescale 1ns/1ps
module ctu_checker
  import ctu_pkg::*;
(
  input wire logic        sys_clk_i, reset_n_i, reg_write_i, reg_read_i, idle_mode_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i, reg_rdata_o,
  input wire logic        unit_run_o, delay_gen_o, edge1_event_o, edge2_event_o, discharge_o, trigger_o
);
  logic [15:0] ctl_q;
  logic        seen_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadow of the control register and of the first-edge flag.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) ctl_q <= 16'h0;
    else if (reg_write_i && reg_addr_i == CTU_ADDR_CONTROL_ONE) ctl_q <= reg_wdata_i & CTU_CONTROL_MASK;
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) seen_q <= 1'b0;
    else if (!ctl_q[11] || !unit_run_o) seen_q <= 1'b0;
    else if (edge1_event_o) seen_q <= 1'b1;
  end
  a_run_state: assert property (unit_run_o == $past(ctl_q[15] && !(ctl_q[13] && idle_mode_i)))
    else $error("run output wrong");
  a_delay_gen: assert property (delay_gen_o |-> $past(ctl_q[12]))
    else $error("delay without enable");
  a_edge_gate: assert property (edge1_event_o || edge2_event_o |-> $past(ctl_q[11]))
    else $error("edge passed while gated");
  a_edge_order: assert property (edge2_event_o && $past(ctl_q[10]) |-> seen_q || edge1_event_o)
    else $error("second edge out of order");
  a_discharge_copy: assert property (discharge_o == $past(ctl_q[9]))
    else $error("discharge wrong");
  a_trigger_gate: assert property (trigger_o |-> $past(ctl_q[8]))
    else $error("trigger while disabled");
  a_read_idle: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0)
    else $error("read data outside read");
  a_read_value: assert property ($past(reg_read_i && reg_addr_i == CTU_ADDR_CONTROL_ONE) |-> reg_rdata_o == $past(ctl_q))
    else $error("control read wrong");
endmodule
bind ctu_control ctu_checker chk (.*);

/* sim/ctu_edge_src.sv */
// Edge source model: raises each edge pin for four cycles on request.
`timescale 1ns/1ps
module ctu_edge_src (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] fire_i,
  output logic      [1:0] pin_o
);
  logic [2:0] hold_q [2];
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q[0] <= 3'h0;
      hold_q[1] <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (fire_i[i]) hold_q[i] <= 3'h4;
        else if (hold_q[i] != 3'h0) hold_q[i] <= hold_q[i] - 3'h1;
      end
    end
  end
  assign pin_o = {hold_q[1] != 3'h0, hold_q[0] != 3'h0};
endmodule

/* sim/ctu_control_tb_top.sv */
// Testbench of the charge time unit control block.
`timescale 1ns/1ps
module ctu_control_tb_top;
  logic        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, idle = 0, run, dg, ev1, ev2, dis, trg;
  logic [3:0]  addr = 0;
  logic [15:0] wd = 0, rdata;
  logic [1:0]  fire = 0, pin;
  int          fail_count = 0, samples_checked = 0, n1 = 0, n2 = 0;
  initial forever #12.5 clk = ~clk;
  ctu_control uut (.sys_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_write_i(wr_s),
    .reg_read_i(rd_s), .reg_rdata_o(rdata), .idle_mode_i(idle), .edge1_i(pin[0]), .edge2_i(pin[1]),
    .unit_run_o(run), .delay_gen_o(dg), .edge1_event_o(ev1), .edge2_event_o(ev2), .discharge_o(dis), .trigger_o(trg));
  ctu_edge_src src (.sys_clk_i(clk), .reset_n_i(rst_n), .fire_i(fire), .pin_o(pin));
  always @(posedge clk) begin
    n1 += (ev1 === 1'b1);
    n2 += (ev2 === 1'b1);
  end
  task automatic cmp(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); addr <= a; wd <= d; wr_s <= 1'b1;
    @(posedge clk); wr_s <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk); addr <= a; rd_s <= 1'b1;
    @(posedge clk); rd_s <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task automatic fire_pins(input logic [1:0] f, input logic [15:0] e);
    n1 = 0; n2 = 0;
    @(posedge clk); fire <= f;
    @(posedge clk); fire <= 2'b00;
    repeat (10) @(posedge clk);
    #1 cmp(16'({n2[7:0], n1[7:0]}), e);
  endtask
  task automatic t_regs;
    rd(4'h0, 16'h0000); cmp({10'h0, run, dg, ev1, ev2, dis, trg}, 16'h0);
    wr(4'h0, 16'hffff); rd(4'h0, 16'hbf00);
    wr(4'h1, 16'h0000); rd(4'h0, 16'hbf00); rd(4'h7, 16'h0000);
    cmp({13'h0, run, dg, dis}, 16'h0007);
  endtask
  task automatic t_idle;
    wr(4'h0, 16'ha000); @(posedge clk) idle <= 1'b1;
    repeat (2) @(posedge clk); #1 cmp({15'h0, run}, 16'h0);
    wr(4'h0, 16'h8000); cmp({13'h0, run, dg, dis}, 16'h0004);
    @(posedge clk) idle <= 1'b0;
    wr(4'h0, 16'h1200); cmp({13'h0, run, dg, dis}, 16'h0001);
  endtask
  task automatic t_edges;
    wr(4'h0, 16'h8d00); fire_pins(2'b10, 16'h0000);
    fire_pins(2'b01, 16'h0001); fire_pins(2'b10, 16'h0100); cmp({15'h0, trg}, 16'h1);
    rd(4'h1, 16'h0003);
    wr(4'h0, 16'h8c00); cmp({15'h0, trg}, 16'h0);
    wr(4'h0, 16'h8000); fire_pins(2'b11, 16'h0000);
    wr(4'h0, 16'h8800); fire_pins(2'b10, 16'h0100);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_idle;
    t_edges;
    complete_run;
  end
  initial begin
    #20us;
    fail_count++;
    complete_run;
  end
endmodule
